// ---- verilog/quad_pot_i2c_command_decoder.sv ----
`timescale 1ns/1ps
// Function
// - First byte: type nibble then four address bits matching address pins.
// - Slot bits 0..3 pick stored-setting slot 0..3 of a pot.
// - Opcode 1001 returns selected wiper position, top two bits zero.
// - Opcode 1010 third byte low six bits load the selected wiper.
// - Opcode 1011 returns addressed stored setting, top two bits zero.
// - Opcode 1100 third byte low six bits go to addressed stored setting.
// - Opcode 0001 copies chosen slot of every pot into its wiper.
// - Opcode 1000 copies every wiper into its chosen slot.
// - Opcode 1110 copies selected wiper into its chosen slot.
// - Opcode 1101 loads selected wiper from its chosen slot.
// - After opcode 0010 acknowledge, master clocks direction bits.
// - Step mode: SCL high with SDA high steps wiper up one tap.
// - Step mode: SCL high with SDA low steps wiper down one tap.
// - Non-volatile writes start programming only after STOP.
// - A stored-setting change takes at most 5 ms.
// - At reset each wiper loads from its slot 0.
module quad_pot_i2c_command_decoder #(
    parameter int NV_CYCLES = pot_cmd_pkg::NV_WRITE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [3:0] hw_addr,
    output logic [5:0] wiper_pos_0,
    output logic [5:0] wiper_pos_1,
    output logic [5:0] wiper_pos_2,
    output logic [5:0] wiper_pos_3,
    output logic nv_busy
);
    import pot_cmd_pkg::*;

    logic [5:0] wiper_position_reg [4];
    logic [5:0] stored_setting_reg [4][4];
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    link_state_type state_reg;
    logic [7:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    logic ack_phase_reg;
    logic ack_drive_reg;
    logic [7:0] tx_reg;
    logic [3:0] opcode_reg;
    logic [1:0] slot_reg;
    logic [1:0] pot_reg;
    logic nv_pending_reg;
    logic boot_reg;
    logic scl_rise, scl_fall, start_cond, stop_cond, scl_s, sda_s;
    logic [7:0] rx_byte;
    logic byte_done;
    logic instr_ok;
    logic nv_start;
    logic opcode_ack_pending;
    logic rdata_drive_reg;

    // Data in the low six bits, top two bits zero
    function automatic logic [7:0] pad6(input logic [5:0] v);
        pad6 = {2'b00, v};
    endfunction : pad6

    // Legal instruction byte check: wiper and step opcodes need zero slot bits, gang opcodes zero pot bits
    function automatic logic legal_instr(input logic [7:0] b);
        logic [3:0] op;
        op = b[OPCODE_MSB:OPCODE_LSB];
        unique case (op)
            OP_READ_WIPER, OP_WRITE_WIPER, OP_STEP:
                legal_instr = (b[SLOT_MSB:SLOT_LSB] == 2'b00);
            OP_GANG_STORED_TO_WIPER, OP_GANG_WIPER_TO_STORED:
                legal_instr = (b[POT_MSB:POT_LSB] == 2'b00);
            OP_READ_STORED, OP_WRITE_STORED, OP_STORED_TO_WIPER,
            OP_WIPER_TO_STORED:
                legal_instr = 1'b1;
            default:
                legal_instr = 1'b0;
        endcase
    endfunction : legal_instr

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; stage 0 is read only by stage 1
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_sync_reg <= 3'b111;
            sda_sync_reg <= 3'b111;
        end
        else if (clk_en)
        begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
        end
    end

    assign scl_s = scl_sync_reg[1];
    assign sda_s = sda_sync_reg[1];
    assign scl_rise = clk_en && scl_s && !scl_sync_reg[2];
    assign scl_fall = clk_en && !scl_s && scl_sync_reg[2];
    // START and STOP are SDA edges while SCL stays high
    assign start_cond = clk_en && scl_s && scl_sync_reg[2] && !sda_s &&
                        sda_sync_reg[2];
    assign stop_cond = clk_en && scl_s && scl_sync_reg[2] && sda_s &&
                       !sda_sync_reg[2];
    assign rx_byte = {shift_reg[6:0], sda_s};
    assign byte_done = scl_rise && !ack_phase_reg && bit_cnt_reg == BIT_LAST;
    assign instr_ok = legal_instr(rx_byte);

    ////////////////////////////////////////////////////////////////////////
    // Bit counter and receive shifter; the ninth clock is the ack slot
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            shift_reg <= 8'h00;
            bit_cnt_reg <= 3'h0;
            ack_phase_reg <= 1'b0;
        end
        else if (start_cond || stop_cond)
        begin
            bit_cnt_reg <= 3'h0;
            ack_phase_reg <= 1'b0;
        end
        else if (scl_rise && (state_reg != ST_STEP || ack_phase_reg))
        begin
            if (ack_phase_reg)
            begin
                ack_phase_reg <= 1'b0;
            end
            else
            begin
                shift_reg <= rx_byte;
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                ack_phase_reg <= (bit_cnt_reg == BIT_LAST);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transaction sequencer
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= ST_IDLE;
            opcode_reg <= 4'h0;
            slot_reg <= 2'b00;
            pot_reg <= 2'b00;
        end
        else if (start_cond)
        begin
            state_reg <= ST_ADDR;
        end
        else if (stop_cond)
        begin
            state_reg <= ST_IDLE;
        end
        else if (byte_done)
        begin
            unique case (state_reg)
                ST_ADDR:
                    // Address match on type nibble and pins
                    if (rx_byte[7:4] == DEVICE_TYPE_ID &&
                        rx_byte[3:0] == hw_addr)
                    begin
                        state_reg <= ST_INSTR;
                    end
                    else
                    begin
                        state_reg <= ST_IGNORE;
                    end
                ST_INSTR:
                    if (instr_ok)
                    begin
                        opcode_reg <= rx_byte[OPCODE_MSB:OPCODE_LSB];
                        slot_reg <= rx_byte[SLOT_MSB:SLOT_LSB];
                        pot_reg <= rx_byte[POT_MSB:POT_LSB];
                        unique case (rx_byte[OPCODE_MSB:OPCODE_LSB])
                            OP_READ_WIPER, OP_READ_STORED:
                                state_reg <= ST_RDATA;
                            OP_WRITE_WIPER, OP_WRITE_STORED:
                                state_reg <= ST_WDATA;
                            OP_STEP:
                                state_reg <= ST_STEP;
                            default:
                                state_reg <= ST_IGNORE;
                        endcase
                    end
                    else
                    begin
                        state_reg <= ST_IGNORE;
                    end
                ST_WDATA:
                    state_reg <= ST_IGNORE;
                ST_RDATA:
                    state_reg <= ST_IGNORE;
                default:
                    state_reg <= state_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data shifter, loaded on the last instruction bit; read data ends after
    // one byte, so a master ack or nack both release the line
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_reg <= 8'h00;
        end
        else if (byte_done && state_reg == ST_INSTR)
        begin
            if (rx_byte[OPCODE_MSB:OPCODE_LSB] == OP_READ_WIPER)
            begin
                tx_reg <= pad6(wiper_position_reg[rx_byte[1:0]]);
            end
            else
            begin
                tx_reg <= pad6(stored_setting_reg[rx_byte[1:0]]
                                                 [rx_byte[3:2]]);
            end
        end
        else if (scl_fall && state_reg == ST_RDATA && !ack_phase_reg &&
                 bit_cnt_reg != 3'h0)
        begin
            tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // SDA driver: ack is set on the falling edge after bit 8, held one bit
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_drive_reg <= 1'b0;
            rdata_drive_reg <= 1'b0;
        end
        else if (start_cond || stop_cond)
        begin
            ack_drive_reg <= 1'b0;
            rdata_drive_reg <= 1'b0;
        end
        else if (scl_fall)
        begin
            rdata_drive_reg <= state_reg == ST_RDATA && !ack_phase_reg;
            // Acks to address, instruction and write data
            ack_drive_reg <= ack_phase_reg &&
                             (state_reg == ST_INSTR || state_reg == ST_RDATA ||
                              state_reg == ST_WDATA || state_reg == ST_STEP ||
                              (state_reg == ST_IGNORE && opcode_ack_pending));
        end
    end

    // A write data byte just taken moves state to IGNORE; keep its ack
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            opcode_ack_pending <= 1'b0;
        end
        else if (start_cond || stop_cond)
        begin
            opcode_ack_pending <= 1'b0;
        end
        else if (byte_done)
        begin
            opcode_ack_pending <= (state_reg == ST_WDATA) ||
                                  (state_reg == ST_INSTR && instr_ok);
        end
    end

    // Read bits move on SCL fall only, so a last 0 bit cannot fake a STOP
    assign sda_oe = ack_drive_reg || (rdata_drive_reg && !tx_reg[7]);
    assign sda_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Stored-setting array; programmed only when STOP ends a pending write
    logic [5:0] nv_data_reg;
    logic nv_gang_reg;
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            nv_pending_reg <= 1'b0;
            nv_data_reg <= STORED_RESET;
            nv_gang_reg <= 1'b0;
            for (int p = 0; p < 4; p++)
            begin
                for (int s = 0; s < 4; s++)
                begin
                    stored_setting_reg[p][s] <= STORED_RESET;
                end
            end
        end
        else if (start_cond)
        begin
            nv_pending_reg <= 1'b0; // Restart aborts the queued write
        end
        else if (stop_cond && nv_pending_reg && !nv_busy)
        begin
            nv_pending_reg <= 1'b0;
            // Launch programming at STOP
            for (int p = 0; p < 4; p++)
            begin
                if (nv_gang_reg)
                begin
                    stored_setting_reg[p][slot_reg] <=
                        wiper_position_reg[p];
                end
                else if (p[1:0] == pot_reg)
                begin
                    stored_setting_reg[p][slot_reg] <= nv_data_reg;
                end
            end
        end
        else if (byte_done && state_reg == ST_WDATA &&
                 opcode_reg == OP_WRITE_STORED)
        begin
            nv_pending_reg <= 1'b1;
            nv_gang_reg <= 1'b0;
            nv_data_reg <= rx_byte[5:0];
        end
        else if (byte_done && state_reg == ST_INSTR && instr_ok)
        begin
            if (rx_byte[7:4] == OP_WIPER_TO_STORED)
            begin
                nv_pending_reg <= 1'b1;
                nv_gang_reg <= 1'b0;
                nv_data_reg <= wiper_position_reg[rx_byte[1:0]];
            end
            else if (rx_byte[7:4] == OP_GANG_WIPER_TO_STORED)
            begin
                nv_pending_reg <= 1'b1;
                nv_gang_reg <= 1'b1;
            end
        end
    end

    assign nv_start = stop_cond && nv_pending_reg && !nv_busy;

    // Programming busy window
    nv_program_timer #(
        .CYCLES(NV_CYCLES)
    ) u_nv_timer (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .start(nv_start),
        .busy(nv_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // Wiper registers: boot recall, writes, copies and stepping
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            boot_reg <= 1'b1;
            for (int p = 0; p < 4; p++)
            begin
                wiper_position_reg[p] <= TAP_MIN;
            end
        end
        else if (clk_en)
        begin
            if (boot_reg)
            begin
                boot_reg <= 1'b0;
                for (int p = 0; p < 4; p++)
                begin
                    wiper_position_reg[p] <= stored_setting_reg[p][0];
                end
            end
            else if (byte_done && state_reg == ST_WDATA &&
                     opcode_reg == OP_WRITE_WIPER)
            begin
                wiper_position_reg[pot_reg] <= rx_byte[5:0];
            end
            else if (byte_done && state_reg == ST_INSTR && instr_ok &&
                     rx_byte[7:4] == OP_STORED_TO_WIPER)
            begin
                wiper_position_reg[rx_byte[1:0]] <=
                    stored_setting_reg[rx_byte[1:0]][rx_byte[3:2]];
            end
            else if (byte_done && state_reg == ST_INSTR && instr_ok &&
                     rx_byte[7:4] == OP_GANG_STORED_TO_WIPER)
            begin
                for (int p = 0; p < 4; p++)
                begin
                    wiper_position_reg[p] <=
                        stored_setting_reg[p][rx_byte[3:2]];
                end
            end
            else if (scl_rise && state_reg == ST_STEP && !ack_phase_reg)
            begin
                // Saturating step on each SCL pulse
                if (sda_s && wiper_position_reg[pot_reg] != TAP_MAX)
                begin
                    wiper_position_reg[pot_reg] <=
                        wiper_position_reg[pot_reg] + 6'h01;
                end
                else if (!sda_s && wiper_position_reg[pot_reg] != TAP_MIN)
                begin
                    wiper_position_reg[pot_reg] <=
                        wiper_position_reg[pot_reg] - 6'h01;
                end
            end
        end
    end

    assign wiper_pos_0 = wiper_position_reg[0];
    assign wiper_pos_1 = wiper_position_reg[1];
    assign wiper_pos_2 = wiper_position_reg[2];
    assign wiper_pos_3 = wiper_position_reg[3];

endmodule : quad_pot_i2c_command_decoder

// ---- verilog/pot_cmd_pkg.sv ----
package pot_cmd_pkg;

    // Device type nibble expected in the first byte (arbitrary value)
    localparam logic [3:0] DEVICE_TYPE_ID = 4'hA;

    // Instruction opcodes
    localparam logic [3:0] OP_READ_WIPER = 4'h9;
    localparam logic [3:0] OP_WRITE_WIPER = 4'hA;
    localparam logic [3:0] OP_READ_STORED = 4'hB;
    localparam logic [3:0] OP_WRITE_STORED = 4'hC;
    localparam logic [3:0] OP_STORED_TO_WIPER = 4'hD;
    localparam logic [3:0] OP_WIPER_TO_STORED = 4'hE;
    localparam logic [3:0] OP_GANG_STORED_TO_WIPER = 4'h1;
    localparam logic [3:0] OP_GANG_WIPER_TO_STORED = 4'h8;
    localparam logic [3:0] OP_STEP = 4'h2;

    // Instruction byte field positions
    localparam int OPCODE_MSB = 7;
    localparam int OPCODE_LSB = 4;
    localparam int SLOT_MSB = 3;
    localparam int SLOT_LSB = 2;
    localparam int POT_MSB = 1;
    localparam int POT_LSB = 0;

    // Wiper limits and reset values
    localparam logic [5:0] TAP_MIN = 6'h00;
    localparam logic [5:0] TAP_MAX = 6'h3F;
    localparam logic [5:0] STORED_RESET = 6'h00;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Non-volatile programming time
    localparam int CLK_FREQ_HZ = 25000000;
    localparam int NV_WRITE_TIME_MS = 5;
    localparam int NV_WRITE_CYCLES = (CLK_FREQ_HZ / 1000) * NV_WRITE_TIME_MS;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_INSTR = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_STEP = 3'b101,
        ST_IGNORE = 3'b110
    } link_state_type;

endpackage : pot_cmd_pkg

// ---- verilog/nv_program_timer.sv ----
`timescale 1ns/1ps
module nv_program_timer #(
    parameter int CYCLES = 125000
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic start,
    output logic busy
);

    logic [23:0] count_reg;

    ////////////////////////////////////////////////////////////////////////
    // Counts down the programming cycle; start while busy is ignored
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count_reg <= 24'h000000;
        end
        else if (clk_en)
        begin
            if (start && count_reg == 24'h000000)
            begin
                count_reg <= 24'(CYCLES);
            end
            else if (count_reg != 24'h000000)
            begin
                count_reg <= count_reg - 24'h000001;
            end
        end
    end

    assign busy = (count_reg != 24'h000000);

endmodule : nv_program_timer

// ---- test/pot_cmd_checker.sv ----
`timescale 1ns/1ps
// Pin-level watcher for the decoder; all times in ref_clk cycles
module pot_cmd_checker #(
    parameter int NV_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [3:0] hw_addr,
    input wire logic [5:0] wiper_pos_0,
    input wire logic [5:0] wiper_pos_1,
    input wire logic [5:0] wiper_pos_2,
    input wire logic [5:0] wiper_pos_3,
    input wire logic nv_busy
);
    import pot_cmd_pkg::*;

    int busy_len;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////
    // Length of the current programming run; catches a stuck timer early
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            busy_len <= 0;
        else
            busy_len <= nv_busy ? busy_len + 1 : 0;
    end

    ////////////////////////////////////////////////////////////////////////
    open_drain_a: assert property (sda_out == 1'h0)
        else $error("sda_out not held low");
    reset_load_a: assert property ($rose(rstn) |-> !nv_busy && !sda_oe
        && {wiper_pos_0, wiper_pos_1, wiper_pos_2, wiper_pos_3}
        == {4{STORED_RESET}}) else $error("bad state after reset");
    // The device may only move SDA while SCL is low
    ack_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda_oe changed with SCL high");
    ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*6])
        else $error("sda drive shorter than a bit");
    start_quiet_a: assert property (scl_in && $fell(sda_in)
        |-> !sda_oe [*8]) else $error("sda driven right after start");
    stop_release_a: assert property (scl_in && $rose(sda_in)
        |-> !sda_oe [*4]) else $error("sda driven after stop");
    busy_at_stop_a: assert property ($rose(nv_busy) |-> scl_in && sda_in)
        else $error("programming began outside stop");
    busy_max_a: assert property (busy_len <= NV_CYCLES + 1)
        else $error("programming ran too long");
    busy_min_a: assert property ($fell(nv_busy) |-> busy_len >= NV_CYCLES - 1)
        else $error("programming ended too soon");
endmodule : pot_cmd_checker

bind quad_pot_i2c_command_decoder pot_cmd_checker #(.NV_CYCLES(NV_CYCLES))
    chk (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .hw_addr(hw_addr),
    .wiper_pos_0(wiper_pos_0), .wiper_pos_1(wiper_pos_1),
    .wiper_pos_2(wiper_pos_2), .wiper_pos_3(wiper_pos_3),
    .nv_busy(nv_busy));

// ---- test/i2c_master_model.sv ----
`timescale 1ns/1ps
// Bus master; SCL rests high between frames, one bit is 8 ref_clk cycles
module i2c_master_model (
    input wire logic ref_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_drv
);
    ////////////////////////////////////////////////////////////////////////
    // Both lines released; the pull-up gives the idle level
    initial
    begin
        scl = 1'h1;
        sda_drv = 1'h1;
    end

    // Quarter bit, launched just after a clock edge to avoid races
    task q(input int n);
        repeat (2 * n) @(posedge ref_clk);
        #1;
    endtask : q

    // SDA falls while SCL is high
    task start();
        q(2);
        sda_drv = 1'h0;
        q(2);
        scl = 1'h0;
    endtask : start

    // SDA rises while SCL is high, then the bus rests
    task stop();
        q(1);
        sda_drv = 1'h0;
        q(1);
        scl = 1'h1;
        q(2);
        sda_drv = 1'h1;
        q(2);
    endtask : stop

    // Data moves mid-low only; sending 1 releases SDA so it can be read
    task bit_io(input logic b, output logic v);
        q(1);
        sda_drv = b;
        q(1);
        scl = 1'h1;
        q(1);
        v = sda;
        q(1);
        scl = 1'h0;
    endtask : bit_io

    // Whole byte MSB first, then the acknowledge slot
    task send(input logic [7:0] d, output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], v);
        bit_io(1'h1, ack);
    endtask : send

    // One read byte, closed with a no-acknowledge
    task recv(output logic [7:0] d);
        logic v;
        for (int i = 7; i >= 0; i--)
            bit_io(1'h1, d[i]);
        bit_io(1'h1, v);
    endtask : recv
endmodule : i2c_master_model

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import pot_cmd_pkg::*;

    localparam int NV_SIM = 20;
    localparam int CYCLE_LIMIT = 60000;
    localparam logic [7:0] BAD [5] = '{{OP_READ_WIPER, 4'h4},
        {OP_STEP, 4'h8}, {OP_GANG_STORED_TO_WIPER, 4'h2},
        {OP_WRITE_WIPER, 4'hC}, 8'h00};
    localparam logic [3:0] XFER [4] = '{OP_STORED_TO_WIPER,
        OP_WIPER_TO_STORED, OP_GANG_STORED_TO_WIPER, OP_GANG_WIPER_TO_STORED};

    logic ref_clk = 1'h0;
    logic rstn = 1'h0;
    logic clk_en = 1'h1;
    logic [3:0] hw_addr = 4'h0;
    logic scl, sda_drv, sda_out, sda_oe, nv_busy, ack, up;
    logic [7:0] rd, dat;
    logic [1:0] s, p;
    logic [5:0] wp [4];
    logic [5:0] ew [4];
    logic [5:0] es [4][4];
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    wire logic sda;

    ////////////////////////////////////////////////////////////////////////
    // Open-drain wire with pull-up
    assign sda = sda_drv & ~(sda_oe & ~sda_out);

    quad_pot_i2c_command_decoder #(.NV_CYCLES(NV_SIM)) DUT (
        .ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .hw_addr(hw_addr),
        .wiper_pos_0(wp[0]), .wiper_pos_1(wp[1]), .wiper_pos_2(wp[2]),
        .wiper_pos_3(wp[3]), .nv_busy(nv_busy));
    i2c_master_model m (.ref_clk(ref_clk), .sda(sda), .scl(scl),
        .sda_drv(sda_drv));

    always #20 ref_clk = ~ref_clk;

    // Hang guard: a run this long means a stuck handshake
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == CYCLE_LIMIT)
        begin
            num_errors++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task check(input string what, input logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task results();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results

    // Saturating one-tap move
    function automatic logic [5:0] tap_step(logic [5:0] v, logic u);
        if (u)
            return (v == TAP_MAX) ? v : v + 6'h01;
        return (v == TAP_MIN) ? v : v - 6'h01;
    endfunction : tap_step

    // Wait out programming, then start, address and instruction
    task open(input logic [7:0] ins);
        for (int i = 0; i < 100 && nv_busy !== 1'h0; i++)
            @(posedge ref_clk);
        m.start();
        m.send({DEVICE_TYPE_ID, hw_addr}, ack);
        check("address ack", {7'h00, ack}, 8'h00);
        m.send(ins, ack);
        check("instruction ack", {7'h00, ack}, 8'h00);
    endtask : open

    task cmd(input logic [7:0] ins, logic [7:0] d, logic wr, logic nv);
        open(ins);
        if (wr)
        begin
            m.send(d, ack);
            check("data ack", {7'h00, ack}, 8'h00);
        end
        check("busy before stop", {7'h00, nv_busy}, 8'h00);
        m.stop();
        repeat (2) @(posedge ref_clk);
        check("busy after stop", {7'h00, nv_busy}, {7'h00, nv});
    endtask : cmd

    task rd_cmd(input logic [7:0] ins, logic [7:0] exp);
        open(ins);
        m.recv(rd);
        m.stop();
        check("read byte", rd, exp);
    endtask : rd_cmd

    task cmp_all();
        for (int i = 0; i < 4; i++)
            check("wiper", {2'h0, wp[i]}, {2'h0, ew[i]});
    endtask : cmp_all

    task rd_all();
        for (int k = 0; k < 16; k++)
            rd_cmd({OP_READ_STORED, 4'(k)}, {2'h0, es[k % 4][k / 4]});
    endtask : rd_all

    // Expected effect of the four transfer kinds
    task xfer_model(input int kind, logic [1:0] sl, logic [1:0] pt);
        for (int i = 0; i < 4; i++)
        begin
            if (kind == 0 && i == pt)
                ew[i] = es[i][sl];
            if (kind == 1 && i == pt)
                es[i][sl] = ew[i];
            if (kind == 2)
                ew[i] = es[i][sl];
            if (kind == 3)
                es[i][sl] = ew[i];
        end
    endtask : xfer_model

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(85207));
        hw_addr = 4'($urandom);
        for (int i = 0; i < 16; i++)
        begin
            es[i / 4][i % 4] = STORED_RESET;
            ew[i % 4] = STORED_RESET;
        end
        repeat (12) @(posedge ref_clk);
        #1;
        rstn = 1'h1;
        repeat (6) @(posedge ref_clk);
        cmp_all();
        $display("done: power-up load");
        // Foreign address, foreign type, then illegal instructions
        for (int k = 0; k < 7; k++)
        begin
            m.start();
            m.send({k == 1 ? ~DEVICE_TYPE_ID : DEVICE_TYPE_ID,
                k == 0 ? ~hw_addr : hw_addr}, ack);
            if (k > 1)
                m.send(BAD[k - 2], ack);
            check("refused ack", {7'h00, ack}, 8'h01);
            m.stop();
        end
        cmp_all();
        $display("done: refusals");
        for (int k = 0; k < 4; k++)
        begin
            dat = {2'h0, 6'($urandom)};
            cmd({OP_WRITE_WIPER, 2'h0, 2'(k)}, dat, 1'h1, 1'h0);
            ew[k] = dat[5:0];
            rd_cmd({OP_READ_WIPER, 2'h0, 2'(k)}, {2'h0, ew[k]});
        end
        $display("done: wiper access");
        for (int k = 0; k < 16; k++)
        begin
            dat = 8'($urandom);
            cmd({OP_WRITE_STORED, 4'(k)}, dat, 1'h1, 1'h1);
            es[k % 4][k / 4] = dat[5:0];
        end
        rd_all();
        $display("done: stored access");
        for (int k = 0; k < 12; k++)
        begin
            s = 2'($urandom);
            p = (k % 4 > 1) ? 2'h0 : 2'($urandom);
            cmd({XFER[k % 4], s, p}, 8'h00, 1'h0, 1'(k % 2));
            xfer_model(k % 4, s, p);
            cmp_all();
        end
        rd_all();
        $display("done: transfers");
        // Climb into the top stop, wander, then pin at the bottom stop
        p = 2'($urandom);
        cmd({OP_WRITE_WIPER, 2'h0, p}, 8'h3D, 1'h1, 1'h0);
        ew[p] = 6'h3D;
        open({OP_STEP, 2'h0, p});
        for (int k = 0; k < 84; k++)
        begin
            up = (k < 4) ? 1'h1 : (k < 14) ? 1'($urandom) : 1'h0;
            m.bit_io(up, ack);
            ew[p] = tap_step(ew[p], up);
            check("step", {2'h0, wp[p]}, {2'h0, ew[p]});
        end
        m.stop();
        cmd({OP_WRITE_WIPER, 2'h0, p}, 8'h2A, 1'h1, 1'h0);
        ew[p] = 6'h2A;
        cmp_all();
        $display("done: step mode");
        results();
    end
endmodule : tb_top
